// ===== rtl/scs_pkg.sv
package scs_pkg;

    // ------------------------------------------------------------------
    // task-file codes
    // ------------------------------------------------------------------
    localparam logic [7:0] CMD_SMART      = 8'hB0;
    localparam logic [7:0] KEY_MID        = 8'h4F;
    localparam logic [7:0] KEY_HIGH       = 8'hC2;
    localparam logic [7:0] FEAT_WRITE_LOG = 8'hD6;
    localparam logic [7:0] FEAT_ENABLE    = 8'hD8;
    localparam logic [7:0] FEAT_DISABLE   = 8'hD9;
    localparam logic [7:0] FEAT_STATUS    = 8'hDA;
    localparam logic [7:0] FEAT_SCT_RD    = 8'hE0;
    localparam logic [7:0] FEAT_SCT_WR    = 8'hE1;
    localparam logic [7:0] DEV_OUT        = 8'hE0;
    localparam logic [7:0] STAT_OK        = 8'h50;
    localparam logic [7:0] STAT_ABORT     = 8'h51;
    localparam logic [7:0] ERR_ABORT      = 8'h04;
    localparam logic [7:0] HEALTH_OK_MID  = 8'h4F;
    localparam logic [7:0] HEALTH_OK_HIGH = 8'hC2;
    localparam logic [7:0] HEALTH_BAD_MID = 8'hF4;
    localparam logic [7:0] HEALTH_BAD_HIGH = 8'h2C;
    localparam logic [15:0] RESERVE_LIMIT = 16'h0003;

    // ------------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [7:0] command;
        logic [7:0] feature;
        logic [7:0] count;
        logic [7:0] lba_low;
        logic [7:0] lba_mid;
        logic [7:0] lba_high;
        logic [7:0] device;
    } scs_taskfile_t;

    typedef struct packed {
        logic [7:0] status;
        logic [7:0] error;
        logic [7:0] lba_mid;
        logic [7:0] lba_high;
        logic [7:0] device;
    } scs_result_t;

    typedef enum logic [2:0] {
        SCS_OP_NONE,
        SCS_OP_WRITE_LOG,
        SCS_OP_ENABLE,
        SCS_OP_DISABLE,
        SCS_OP_STATUS,
        SCS_OP_SCT,
        SCS_OP_ABORT
    } scs_op_t;

endpackage : scs_pkg

// ===== rtl/scs_decode.sv
`timescale 1ns/1ps
module scs_decode (
    input  scs_pkg::scs_taskfile_t tf,
    input  wire logic              smart_on,
    output scs_pkg::scs_op_t       op
);
    always_comb begin
        if (tf.command != scs_pkg::CMD_SMART) begin
            op = scs_pkg::SCS_OP_NONE;
        end else if (tf.lba_mid != scs_pkg::KEY_MID || tf.lba_high != scs_pkg::KEY_HIGH) begin
            op = scs_pkg::SCS_OP_ABORT;
        end else if (tf.feature == scs_pkg::FEAT_ENABLE) begin
            op = scs_pkg::SCS_OP_ENABLE;
        end else if (tf.feature == scs_pkg::FEAT_SCT_RD || tf.feature == scs_pkg::FEAT_SCT_WR) begin
            op = scs_pkg::SCS_OP_SCT;
        end else if (!smart_on) begin
            op = scs_pkg::SCS_OP_ABORT;
        end else if (tf.feature == scs_pkg::FEAT_WRITE_LOG) begin
            op = scs_pkg::SCS_OP_WRITE_LOG;
        end else if (tf.feature == scs_pkg::FEAT_DISABLE) begin
            op = scs_pkg::SCS_OP_DISABLE;
        end else if (tf.feature == scs_pkg::FEAT_STATUS) begin
            op = scs_pkg::SCS_OP_STATUS;
        end else begin
            op = scs_pkg::SCS_OP_ABORT;
        end
    end
endmodule // scs_decode

// ===== rtl/scs_smart.sv
`timescale 1ns/1ps
// Notes on behaviour
// - write log: feature D6h, PIO data-out
// - enable feature D8h makes SMART available
// - enabled setting kept non-volatile
// - repeated enable completes, changes nothing
// - disable feature D9h turns SMART off
// - while off abort all but enable, SCT
// - return status reports device E0h
// - over three reserved blocks: 4Fh C2h
// - three or fewer: F4h 2Ch
module scs_smart #(
    parameter int LOG_WORDS = 256
) (
    input  wire logic                   clk,
    input  wire logic                   reset_n,
    input  wire logic                   cmd_valid,
    input  scs_pkg::scs_taskfile_t      cmd_tf,
    output logic                        cmd_ready,
    input  wire logic                   nv_valid,
    input  wire logic                   nv_smart_on,
    output logic                        nv_write,
    output logic                        nv_wdata,
    input  wire logic [15:0]            reserve_blocks,
    input  wire logic                   wr_valid,
    input  wire logic [15:0]            wr_data,
    output logic                        wr_ready,
    output logic                        log_we,
    output logic [7:0]                  log_addr,
    output logic [15:0]                 log_wdata,
    output logic                        done,
    output scs_pkg::scs_result_t        result,
    output logic                        smart_on,
    output logic                        sct_req
);
    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    // load waits for the stored setting before any command is taken
    typedef enum logic [1:0] {
        SCS_ST_LOAD,
        SCS_ST_IDLE,
        SCS_ST_DATA,
        SCS_ST_DONE
    } scs_state_t;

    typedef struct packed {
        scs_state_t           state;
        logic                 smart_on;
        logic                 nv_write;
        logic                 nv_wdata;
        logic [7:0]           log_addr;
        logic [15:0]          words_left;
        logic                 log_we;
        logic [15:0]          log_wdata;
        logic                 done;
        logic                 sct_req;
        scs_pkg::scs_result_t result;
    } scs_regs_t;

    scs_regs_t        s_reg;
    scs_regs_t        s_next;
    scs_pkg::scs_op_t op;
    logic             rst_n_sync;

    // ------------------------------------------------------------------
    // reset release
    // ------------------------------------------------------------------
    // asserts at once, releases two edges later so no flop sees a runt edge
    logic [1:0] rsync_reg;
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rsync_reg <= 2'h0;
        end else begin
            rsync_reg <= {rsync_reg[0], 1'b1};
        end
    end
    assign rst_n_sync = rsync_reg[1];

    // ------------------------------------------------------------------
    // command decode
    // ------------------------------------------------------------------
    // op follows the live task file, so it only counts with cmd_valid
    scs_decode u_decode (
        .tf       (cmd_tf),
        .smart_on (s_reg.smart_on),
        .op       (op)
    );

    // ------------------------------------------------------------------
    // command engine
    // ------------------------------------------------------------------
    always_comb begin
        s_next           = s_reg;
        // strobes live for one cycle only
        s_next.nv_write  = 1'b0;
        s_next.log_we    = 1'b0;
        s_next.done      = 1'b0;
        s_next.sct_req   = 1'b0;
        case (s_reg.state)
            SCS_ST_LOAD: begin
                // setting lives off-chip; wait for the stored copy
                if (nv_valid) begin
                    s_next.smart_on = nv_smart_on;
                    s_next.state    = SCS_ST_IDLE;
                end
            end

            SCS_ST_IDLE: begin
                if (cmd_valid) begin
                    s_next.state         = SCS_ST_DONE;
                    s_next.result        = '0;
                    s_next.result.status = scs_pkg::STAT_OK;
                    s_next.result.device = scs_pkg::DEV_OUT;
                    case (op)
                        scs_pkg::SCS_OP_ENABLE: begin
                            // repeat enable leaves data untouched
                            if (!s_reg.smart_on) begin
                                s_next.smart_on = 1'b1;
                                s_next.nv_write = 1'b1;
                                s_next.nv_wdata = 1'b1;
                            end
                        end

                        scs_pkg::SCS_OP_DISABLE: begin
                            s_next.smart_on = 1'b0;
                            s_next.nv_write = 1'b1;
                            s_next.nv_wdata = 1'b0;
                        end

                        scs_pkg::SCS_OP_STATUS: begin
                            // the limit itself already counts as worn out
                            if (reserve_blocks > scs_pkg::RESERVE_LIMIT) begin
                                s_next.result.lba_mid  = scs_pkg::HEALTH_OK_MID;
                                s_next.result.lba_high = scs_pkg::HEALTH_OK_HIGH;
                            end else begin
                                s_next.result.lba_mid  = scs_pkg::HEALTH_BAD_MID;
                                s_next.result.lba_high = scs_pkg::HEALTH_BAD_HIGH;
                            end
                        end

                        scs_pkg::SCS_OP_WRITE_LOG: begin
                            // count is in sectors; zero closes at once with no data
                            s_next.log_addr   = cmd_tf.lba_low;
                            s_next.words_left = 16'(cmd_tf.count * LOG_WORDS);
                            if (cmd_tf.count != 8'h00) begin
                                s_next.state = SCS_ST_DATA;
                            end
                        end

                        scs_pkg::SCS_OP_SCT: begin
                            // transport itself is handled by the firmware
                            s_next.sct_req = 1'b1;
                        end

                        scs_pkg::SCS_OP_NONE: begin
                            // foreign opcode: no answer, last result kept
                            s_next.result = s_reg.result;
                            s_next.state  = SCS_ST_IDLE;
                        end

                        default: begin
                            s_next.result.status = scs_pkg::STAT_ABORT;
                            s_next.result.error  = scs_pkg::ERR_ABORT;
                        end
                    endcase
                end
            end

            SCS_ST_DATA: begin
                // one word per beat; the count ends at one, not zero
                if (wr_valid) begin
                    s_next.log_we     = 1'b1;
                    s_next.log_wdata  = wr_data;
                    s_next.words_left = s_reg.words_left - 16'h0001;
                    if (s_reg.words_left == 16'h0001) begin
                        s_next.state = SCS_ST_DONE;
                    end
                end
            end

            SCS_ST_DONE: begin
                // ready returns with done, so the next take may share this edge
                s_next.done  = 1'b1;
                s_next.state = SCS_ST_IDLE;
            end

            default: begin
                s_next.state = SCS_ST_IDLE;
            end
        endcase
    end

    // ------------------------------------------------------------------
    // register update
    // ------------------------------------------------------------------
    // result holds until the next command is taken
    always_ff @(posedge clk or negedge rst_n_sync) begin
        if (!rst_n_sync) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    // ready strobes are combinational so a word can be taken every cycle
    assign cmd_ready = (s_reg.state == SCS_ST_IDLE);
    assign wr_ready  = (s_reg.state == SCS_ST_DATA);
    assign nv_write  = s_reg.nv_write;
    assign nv_wdata  = s_reg.nv_wdata;
    assign log_we    = s_reg.log_we;
    assign log_addr  = s_reg.log_addr;
    assign log_wdata = s_reg.log_wdata;
    assign done      = s_reg.done;
    assign result    = s_reg.result;
    assign smart_on  = s_reg.smart_on;
    assign sct_req   = s_reg.sct_req;
endmodule // scs_smart

// ===== sim/scs_host_model.sv
`timescale 1ns/1ps
// ------------------------------------------------------------------
// host: holds a command until taken, streams log words
// ------------------------------------------------------------------
module scs_host_model (
    input wire logic               clk,
    input wire logic               go,
    input wire logic               slow,
    input scs_pkg::scs_taskfile_t  tf,
    input wire logic               cmd_ready,
    input wire logic               wr_ready,
    output scs_pkg::scs_taskfile_t cmd_tf,
    output logic                   cmd_valid,
    output logic                   wr_valid,
    output logic [15:0]            wr_data
);
    logic [15:0] d = 16'h0000;
    initial begin
        cmd_valid = 1'b0;
        wr_valid = 1'b0;
        cmd_tf = '0;
    end
    // idle data is scrambled so a stale word never looks valid
    assign wr_data = wr_valid ? d : ~d;
    always @(posedge clk) begin
        if (cmd_valid && cmd_ready) begin
            cmd_valid <= #1 1'b0;
            cmd_tf    <= #1 ~cmd_tf;
        end else if (go) begin
            cmd_valid <= #1 1'b1;
            cmd_tf    <= #1 tf;
        end
        if (wr_valid && wr_ready) begin
            wr_valid <= #1 !slow;
            d        <= #1 d + 16'h1357;
        end else
            wr_valid <= #1 1'b1;
    end
endmodule // scs_host_model

// ===== sim/scs_smart_chk.sv
`timescale 1ns/1ps
module scs_smart_chk #(
    parameter int LOG_WORDS = 256
) (
    input wire logic              clk,
    input wire logic              reset_n,
    input wire logic              cmd_valid,
    input scs_pkg::scs_taskfile_t cmd_tf,
    input wire logic              cmd_ready,
    input wire logic              nv_write,
    input wire logic              nv_wdata,
    input wire logic [15:0]       reserve_blocks,
    input wire logic              wr_valid,
    input wire logic [15:0]       wr_data,
    input wire logic              wr_ready,
    input wire logic              log_we,
    input wire logic [15:0]       log_wdata,
    input wire logic              done,
    input scs_pkg::scs_result_t   result,
    input wire logic              smart_on,
    input wire logic              sct_req
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    logic t, k, fe, fd, fs, lo, sct;
    assign t   = cmd_valid && cmd_ready && cmd_tf.command == scs_pkg::CMD_SMART;
    assign k   = t && cmd_tf.lba_mid == scs_pkg::KEY_MID && cmd_tf.lba_high == scs_pkg::KEY_HIGH;
    assign fe  = cmd_tf.feature == scs_pkg::FEAT_ENABLE;
    assign fd  = cmd_tf.feature == scs_pkg::FEAT_DISABLE;
    assign fs  = k && smart_on && cmd_tf.feature == scs_pkg::FEAT_STATUS;
    assign sct = cmd_tf.feature[7:1] == scs_pkg::FEAT_SCT_RD[7:1];
    assign lo  = reserve_blocks <= scs_pkg::RESERVE_LIMIT;
    sequence s_ok; ##2 done && result.status == scs_pkg::STAT_OK; endsequence
    sequence s_ab; ##2 done && result.status == scs_pkg::STAT_ABORT; endsequence
    property p_en; k && fe |-> s_ok and ##1 smart_on; endproperty
    a_en: assert property (p_en) else $error("enable did not complete");
    property p_nv; k && fe && !smart_on |=> nv_write && nv_wdata; endproperty
    a_nv: assert property (p_nv) else $error("enabled setting not stored");
    property p_re; k && fe && smart_on |=> !nv_write && smart_on ##1 smart_on; endproperty
    a_re: assert property (p_re) else $error("repeated enable changed state");
    property p_dis; k && fd && smart_on |-> s_ok and ##1 (!smart_on && nv_write); endproperty
    a_dis: assert property (p_dis) else $error("disable did not turn off");
    property p_ab; t && !smart_on && !fe && !sct |-> s_ab; endproperty
    a_ab: assert property (p_ab) else $error("command not aborted while off");
    property p_sct; k && sct |-> (##1 sct_req) and s_ok; endproperty
    a_sct: assert property (p_sct) else $error("transport command not passed on");
    property p_dev; done && result.status == scs_pkg::STAT_OK |-> result.device == 8'hE0;
    endproperty
    a_dev: assert property (p_dev) else $error("device output wrong");
    property p_good; fs && !lo |-> ##2 done && result.lba_mid == 8'h4F && result.lba_high == 8'hC2;
    endproperty
    a_good: assert property (p_good) else $error("healthy verdict wrong");
    property p_bad; fs && lo |-> ##2 done && result.lba_mid == 8'hF4 && result.lba_high == 8'h2C;
    endproperty
    a_bad: assert property (p_bad) else $error("threshold verdict wrong");
    property p_log; wr_valid && wr_ready |=> log_we && log_wdata == $past(wr_data); endproperty
    a_log: assert property (p_log) else $error("log word lost");
endmodule // scs_smart_chk

bind scs_smart scs_smart_chk #(.LOG_WORDS(LOG_WORDS)) u_chk (.clk(clk), .reset_n(reset_n),
    .cmd_valid(cmd_valid), .cmd_tf(cmd_tf), .cmd_ready(cmd_ready), .nv_write(nv_write),
    .nv_wdata(nv_wdata), .reserve_blocks(reserve_blocks), .wr_valid(wr_valid),
    .wr_data(wr_data), .wr_ready(wr_ready), .log_we(log_we), .log_wdata(log_wdata),
    .done(done), .result(result), .smart_on(smart_on), .sct_req(sct_req));

// ===== sim/scs_smart_tb.sv
`timescale 1ns/1ps
module scs_smart_tb;
    logic                   clk = 1'b0;
    logic                   reset_n = 1'b0;
    logic                   go = 1'b0;
    logic                   slow = 1'b0;
    logic                   nv_valid = 1'b0;
    logic                   nv_q = 1'b0;
    logic [15:0]            rsv = 16'h0010;
    logic [15:0]            lfsr = 16'h0037;
    scs_pkg::scs_taskfile_t tf = '0;
    scs_pkg::scs_taskfile_t cmd_tf;
    scs_pkg::scs_result_t   result;
    logic                   cmd_valid, cmd_ready, wr_valid, wr_ready, nv_write, nv_wdata;
    logic                   log_we, done, smart_on, sct_req;
    logic                   exp_on = 1'b0;
    logic [15:0]            wr_data, log_wdata;
    logic [7:0]             log_addr;
    int                     err_total = 0;
    int                     n_tests = 0;
    int                     n_we = 0;
    int                     n_sct = 0;
    initial forever #25 clk = ~clk;
    scs_host_model host (.clk(clk), .go(go), .slow(slow), .tf(tf), .cmd_ready(cmd_ready),
        .wr_ready(wr_ready), .cmd_tf(cmd_tf), .cmd_valid(cmd_valid), .wr_valid(wr_valid),
        .wr_data(wr_data));
    scs_smart uut (.clk(clk), .reset_n(reset_n), .cmd_valid(cmd_valid), .cmd_tf(cmd_tf),
        .cmd_ready(cmd_ready), .nv_valid(nv_valid), .nv_smart_on(nv_q), .nv_write(nv_write),
        .nv_wdata(nv_wdata), .reserve_blocks(rsv), .wr_valid(wr_valid), .wr_data(wr_data),
        .wr_ready(wr_ready), .log_we(log_we), .log_addr(log_addr), .log_wdata(log_wdata),
        .done(done), .result(result), .smart_on(smart_on), .sct_req(sct_req));
    function automatic logic [15:0] nxt(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction
    // with good keys, enable and transport always pass; write log, disable and status only while SMART is on
    function automatic logic exp_ok(input logic [7:0] f, input logic bad, input logic on);
        if (bad)
            return 1'b0;
        if (f == 8'hD8 || f == 8'hE0 || f == 8'hE1)
            return 1'b1;
        return on && (f == 8'hD6 || f == 8'hD9 || f == 8'hDA);
    endfunction
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic test_done();
        $display("compares %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // ------------------------------------------------------------------
    // one command, status worked out from the keys and the prior state
    // ------------------------------------------------------------------
    task automatic cmd(input logic [7:0] f, input logic [7:0] cnt, input logic bad);
        logic ok;
        ok = exp_ok(f, bad, exp_on);
        tf = '{8'hB0, f, cnt, lfsr[7:0], bad ? 8'h00 : 8'h4F, 8'hC2, 8'hA0};
        lfsr = nxt(lfsr);
        go = 1'b1;
        @(posedge clk) #1 go = 1'b0;
        for (int i = 0; i < 3000 && done !== 1'b1; i++)
            @(posedge clk) #1;
        if (done !== 1'b1) begin
            err_total++;
            test_done();
        end
        if (ok && f == 8'hD8)
            exp_on = 1'b1;
        if (ok && f == 8'hD9)
            exp_on = 1'b0;
        chk({8'h00, result.status}, ok ? 16'h0050 : 16'h0051);
        if (!ok)
            chk({8'h00, result.error}, 16'h0004);
        chk({15'h0000, smart_on}, {15'h0000, exp_on});
    endtask
    // store outlives reset, as the drive's flash would
    task automatic rst();
        reset_n = 1'b0;
        @(posedge clk) #1 reset_n = 1'b1;
        repeat (6) @(posedge clk);
        #1 chk({15'h0000, smart_on}, {15'h0000, exp_on});
    endtask
    always @(posedge clk) begin
        if (nv_write)
            nv_q <= nv_wdata;
        if (log_we) begin
            n_we <= n_we + 1;
            chk({8'h00, log_addr}, {8'h00, tf.lba_low});
        end
        if (sct_req)
            n_sct <= n_sct + 1;
    end
    initial begin
        repeat (12) @(posedge clk);
        #1 reset_n = 1'b1;
        nv_valid = 1'b1;
        repeat (6) @(posedge clk);
        #1 cmd(8'hDA, 8'h00, 1'b0);
        cmd(8'hD9, 8'h00, 1'b0);
        cmd(8'hE1, 8'h00, 1'b0);
        chk(16'(n_sct), 16'h0001);
        cmd(8'hD8, 8'h00, 1'b1);
        cmd(8'hD8, 8'h00, 1'b0);
        cmd(8'hD8, 8'h00, 1'b0);
        chk({15'h0000, smart_on}, 16'h0001);
        cmd(8'hD4, 8'h00, 1'b0);
        cmd(8'hE0, 8'h00, 1'b0);
        chk(16'(n_sct), 16'h0002);
        for (int k = 0; k < 10; k++) begin
            rsv = k < 4 ? 16'(k + 2) : (k == 4 ? 16'h0000 : lfsr);
            cmd(8'hDA, 8'h00, 1'b0);
            chk({result.lba_mid, result.lba_high},
                rsv > 16'h0003 ? 16'h4FC2 : 16'hF42C);
            chk({8'h00, result.device}, 16'h00E0);
        end
        slow = 1'b1;
        n_we = 0;
        cmd(8'hD6, 8'h01, 1'b0);
        chk(16'(n_we), 16'h0100);
        cmd(8'hD6, 8'h00, 1'b0);
        chk(16'(n_we), 16'h0100);
        rst();
        cmd(8'hD9, 8'h00, 1'b0);
        chk({15'h0000, smart_on}, 16'h0000);
        cmd(8'hD9, 8'h00, 1'b0);
        rst();
        test_done();
    end
endmodule // scs_smart_tb
